// >>> design/fwsr_pkg.sv
// constants, types and register map of the flash status controller
// assumes a 40 MHz clock and a byte-wide parallel flash on the pins
package fwsr_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 25;
  localparam int T_WP_NS  = 50;  // write strobe low time
  localparam int T_ACC_NS = 100; // read access before sampling
  localparam int T_REC_NS = 25;  // strobes high between cycles
  localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADDR  = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam int CTRL_PROG   = 0;
  localparam int CTRL_SERASE = 1;
  localparam int CTRL_CERASE = 2;
  localparam int CTRL_RESET  = 3;
  localparam int CTRL_POLL   = 4;
  localparam int CTRL_PAUSE  = 5;
  localparam int CTRL_RESUME = 6;

  // ----------------------------------------------------------------
  // flash command bytes and status bit positions
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_UNLK1 = 8'hAA;
  localparam logic [7:0]  CMD_UNLK2 = 8'h55;
  localparam logic [7:0]  CMD_PROG  = 8'hA0;
  localparam logic [7:0]  CMD_ERASE = 8'h80;
  localparam logic [7:0]  CMD_CHIP  = 8'h10;
  localparam logic [7:0]  CMD_SECT  = 8'h30;
  localparam logic [7:0]  CMD_RESET = 8'hF0;
  localparam logic [16:0] ADR_UNLK1 = 17'h00555;
  localparam logic [16:0] ADR_UNLK2 = 17'h002AA;
  localparam logic [2:0]  LEN_PROG  = 3'h4;
  localparam logic [2:0]  LEN_ERASE = 3'h6;
  localparam logic [2:0]  LEN_RESET = 3'h1;
  localparam int POLLING_STATUS_BIT  = 7;
  localparam int TOGGLE_BIT_ONE      = 6;
  localparam int TIMEOUT_FAILURE_BIT = 5;

  typedef enum logic [1:0] {OP_PROG, OP_SERASE, OP_CERASE, OP_RESET}
    fwsr_op_t;
  typedef enum logic [3:0] {S_IDLE, S_CMD, S_RD1, S_RD2, S_RE, S_FIN,
    S_RST, S_PAUSE} fwsr_st_t;
  typedef enum logic [1:0] {B_IDLE, B_ACT, B_REC} fwsr_bst_t;

endpackage

// >>> design/fwsr_cyc_if.sv
// one flash bus cycle request between sequencer and pin engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface fwsr_cyc_if;
  logic        req;
  logic        wr;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctl (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// >>> design/fwsr_bus_cycle.sv
// pin engine: runs one write or read cycle on the flash pins
// assumes dq input is synchronous to clk_in; pins driven from flops
`timescale 1ns/1ps
module fwsr_bus_cycle
  import fwsr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  fwsr_cyc_if.eng          cyc,
  output logic [16:0]      flash_addr_out,
  output logic             flash_ce_n_out,
  output logic             flash_we_n_out,
  output logic             flash_oe_n_out,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [7:0]  flash_dq_in
);

  typedef struct packed {
    fwsr_bst_t   st;
    logic [3:0]  cnt;
    logic        wr;
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic        dq_oe;
    logic        done;
  } fwsr_bus_t;

  localparam fwsr_bus_t BUS_RST = '{st: B_IDLE, cnt: 4'h0, wr: 1'b0,
    addr: 17'h00000, wdata: 8'h00, rdata: 8'h00, ce_n: 1'b1,
    we_n: 1'b1, oe_n: 1'b1, dq_oe: 1'b0, done: 1'b0};

  fwsr_bus_t q;
  fwsr_bus_t d;

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  // every read is its own chip-select frame so toggle bits advance
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    case (q.st)
      B_IDLE:
        if (cyc.req)
        begin
          d.addr  = cyc.addr;
          d.wdata = cyc.wdata;
          d.wr    = cyc.wr;
          d.ce_n  = 1'b0;
          d.we_n  = ~cyc.wr;
          d.oe_n  = cyc.wr;
          d.dq_oe = cyc.wr;
          d.cnt   = cyc.wr ? WP_CYC : ACC_CYC;
          d.st    = B_ACT;
        end
      B_ACT:
        if (q.cnt > 4'h1)
          d.cnt = q.cnt - 4'h1;
        else
        begin
          if (!q.wr)
            d.rdata = flash_dq_in;
          d.ce_n = 1'b1;
          d.we_n = 1'b1;
          d.oe_n = 1'b1;
          d.cnt  = REC_CYC;
          d.st   = B_REC;
        end
      B_REC:
        if (q.cnt > 4'h1)
          d.cnt = q.cnt - 4'h1;
        else
        begin
          // data held past the strobe's rise for hold time
          d.dq_oe = 1'b0;
          d.done  = 1'b1;
          d.st    = B_IDLE;
        end
      default:
        d = BUS_RST;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      q <= BUS_RST;
    else
      q <= d;
  end

  assign cyc.done        = q.done;
  assign cyc.rdata       = q.rdata;
  assign flash_addr_out  = q.addr;
  assign flash_ce_n_out  = q.ce_n;
  assign flash_we_n_out  = q.we_n;
  assign flash_oe_n_out  = q.oe_n;
  assign flash_dq_out    = q.wdata;
  assign flash_dq_oe_out = q.dq_oe;

endmodule

// >>> design/fwsr_host.sv
// host controller: issues program/erase/reset and checks completion
// assumes a byte-wide flash on the pins and a simple register port
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// - host polls program status at the programmed address
// - host polls erase status inside a selected sector
// - data trusted only on reads after the one showing completion
// - host reads twice and compares toggle bit; equal means finished
// - toggling with timeout bit high: recheck, still toggling is failure
// - host leaving the check restarts it from the double read
// - after a timeout failure host writes reset before reading data
// - reset is one write of F0 to any address
module fwsr_host
  import fwsr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic [16:0]      flash_addr_out,
  output logic             flash_ce_n_out,
  output logic             flash_we_n_out,
  output logic             flash_oe_n_out,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [7:0]  flash_dq_in
);

  typedef struct packed {
    fwsr_st_t    st;
    fwsr_op_t    op;
    logic        poll;
    logic        iss;
    logic [2:0]  idx;
    logic [16:0] tgt;
    logic [7:0]  wdat;
    logic [7:0]  prev;
    logic [7:0]  last;
    logic        done;
    logic        fail;
    logic        pause;
    logic [31:0] rdat;
  } fwsr_main_t;

  localparam fwsr_main_t MAIN_RST = '{st: S_IDLE, op: OP_PROG,
    default: '0};

  fwsr_main_t q;
  fwsr_main_t d;
  fwsr_cyc_if cyc ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [24:0] cmd_step(input fwsr_op_t op,
    input logic [2:0] idx, input logic [16:0] tgt, input logic [7:0] wd);
    logic [24:0] r;
    r = {ADR_UNLK1, CMD_UNLK1};
    if (op == OP_RESET)
      r = {tgt, CMD_RESET};
    else
      case (idx)
        3'h0: r = {ADR_UNLK1, CMD_UNLK1};
        3'h1: r = {ADR_UNLK2, CMD_UNLK2};
        3'h2: r = {ADR_UNLK1, (op == OP_PROG) ? CMD_PROG : CMD_ERASE};
        3'h3: r = (op == OP_PROG) ? {tgt, wd} : {ADR_UNLK1, CMD_UNLK1};
        3'h4: r = {ADR_UNLK2, CMD_UNLK2};
        default: r = (op == OP_SERASE) ? {tgt, CMD_SECT}
                                       : {ADR_UNLK1, CMD_CHIP};
      endcase
    return r;
  endfunction

  function automatic logic [2:0] cmd_len(input fwsr_op_t op);
    case (op)
      OP_PROG:  return LEN_PROG;
      OP_RESET: return LEN_RESET;
      default:  return LEN_ERASE;
    endcase
  endfunction

  // polling target: true data bit for program, 1 for erase
  function automatic logic poll_ok(input logic [7:0] cur,
    input fwsr_op_t op, input logic [7:0] wd);
    return cur[POLLING_STATUS_BIT] ==
      ((op == OP_PROG) ? wd[POLLING_STATUS_BIT] : 1'b1);
  endfunction

  function automatic logic tgl_same(input logic [7:0] a,
    input logic [7:0] b);
    return a[TOGGLE_BIT_ONE] == b[TOGGLE_BIT_ONE];
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic        cyc_busy;
  logic [24:0] step;
  logic [7:0]  rd;

  assign cyc_busy = (q.st != S_IDLE) && (q.st != S_PAUSE);
  assign step     = cmd_step(q.op, q.idx, q.tgt, q.wdat);
  assign rd       = cyc.rdata;

  // status reads always use the target address, never elsewhere
  assign cyc.req   = cyc_busy && !q.iss;
  assign cyc.wr    = (q.st == S_CMD) || (q.st == S_RST);
  assign cyc.addr  = (q.st == S_CMD) ? step[24:8] : q.tgt;
  assign cyc.wdata = (q.st == S_RST) ? CMD_RESET : step[7:0];

  always_comb
  begin
    d = q;
    d.rdat = 32'h00000000;
    if (cyc.req)
      d.iss = 1'b1;
    if (reg_wr_in)
      case (reg_addr_in)
        REG_ADDR:  d.tgt  = reg_wdata_in[16:0];
        REG_WDATA: d.wdat = reg_wdata_in[7:0];
        REG_CTRL:
        begin
          if (q.st == S_IDLE && (|reg_wdata_in[CTRL_RESET:CTRL_PROG]))
          begin
            d.op   = reg_wdata_in[CTRL_RESET]  ? OP_RESET  :
                     reg_wdata_in[CTRL_CERASE] ? OP_CERASE :
                     reg_wdata_in[CTRL_SERASE] ? OP_SERASE : OP_PROG;
            d.poll = reg_wdata_in[CTRL_POLL];
            d.idx  = 3'h0;
            d.done = 1'b0;
            d.fail = 1'b0;
            d.st   = S_CMD;
          end
          if (reg_wdata_in[CTRL_PAUSE] && cyc_busy && q.st != S_CMD)
            d.pause = 1'b1;
          if (reg_wdata_in[CTRL_RESUME] && q.st == S_PAUSE)
            d.st = S_RD1;
        end
        default: ;
      endcase
    if (reg_rd_in)
      case (reg_addr_in)
        REG_CTRL:  d.rdat = {27'h0, q.poll, 2'h0, q.op};
        REG_ADDR:  d.rdat = {15'h0, q.tgt};
        REG_WDATA: d.rdat = {24'h0, q.wdat};
        REG_STAT:  d.rdat = {16'h0, q.last, 4'h0,
                             q.st == S_PAUSE, q.fail, q.done, cyc_busy};
        default:   d.rdat = 32'h00000000;
      endcase
    if (cyc.done)
    begin
      d.iss = 1'b0;
      case (q.st)
        S_CMD:
          if (q.idx == cmd_len(q.op) - 3'h1)
          begin
            d.done = (q.op == OP_RESET);
            d.st   = (q.op == OP_RESET) ? S_IDLE : S_RD1;
          end
          else
            d.idx = q.idx + 3'h1;
        S_RD1:
        begin
          // first read of a (re)started check records the byte; only polling mode also tests it
          d.prev = rd;
          if (q.poll && poll_ok(rd, q.op, q.wdat))
            d.st = S_FIN;
          else if (q.poll && rd[TIMEOUT_FAILURE_BIT])
            d.st = S_RE;
          else if (d.pause)
            d.st = S_PAUSE;
          else
            d.st = q.poll ? S_RD1 : S_RD2;
        end
        S_RD2:
        begin
          d.prev = rd;
          if (tgl_same(rd, q.prev))
            d.st = S_FIN;
          else if (rd[TIMEOUT_FAILURE_BIT])
            d.st = S_RE;
          else if (d.pause)
            d.st = S_PAUSE;
        end
        S_RE:
          if (q.poll ? poll_ok(rd, q.op, q.wdat) : tgl_same(rd, q.prev))
            d.st = S_FIN;
          else
          begin
            d.fail = 1'b1;
            d.st   = S_RST;
          end
        S_FIN:
        begin
          // completion read may mix bits; keep the read after it
          d.last = rd;
          d.done = 1'b1;
          d.st   = S_IDLE;
        end
        S_RST:
        begin
          d.done = 1'b1;
          d.st   = S_IDLE;
        end
        default: d.st = S_IDLE;
      endcase
    end
    if (d.st == S_PAUSE)
      d.pause = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      q <= MAIN_RST;
    else
      q <= d;
  end

  assign reg_rdata_out = q.rdat;

  fwsr_bus_cycle u_fwsr_bus_cycle (
    .clk_in          (clk_in),
    .reset_in        (reset_in),
    .cyc             (cyc.eng),
    .flash_addr_out  (flash_addr_out),
    .flash_ce_n_out  (flash_ce_n_out),
    .flash_we_n_out  (flash_we_n_out),
    .flash_oe_n_out  (flash_oe_n_out),
    .flash_dq_out    (flash_dq_out),
    .flash_dq_oe_out (flash_dq_oe_out),
    .flash_dq_in     (flash_dq_in)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_stat_addr;
    @(posedge clk_in) disable iff (reset_in)
    (cyc.req && !cyc.wr) |-> ##1 (flash_addr_out == $past(q.tgt));
  endproperty
  a_stat_addr: assert property (p_stat_addr)
    else $error("status read not at target address");

  property p_erase_addr;
    @(posedge clk_in) disable iff (reset_in)
    (cyc.req && !cyc.wr && q.op == OP_SERASE) |-> ##[1:2]
      (!flash_oe_n_out && flash_addr_out == q.tgt);
  endproperty
  a_erase_addr: assert property (p_erase_addr)
    else $error("erase status read outside selected sector");

  property p_fin_after;
    @(posedge clk_in) disable iff (reset_in)
    ($rose(q.done) && $past(q.op) != OP_RESET && !$past(q.fail)) |->
      $past(q.st) == S_FIN;
  endproperty
  a_fin_after: assert property (p_fin_after)
    else $error("done without a trailing data read");

  property p_double;
    @(posedge clk_in) disable iff (reset_in)
    (q.st == S_RD2 && $past(q.st) != S_RD2) |-> $past(q.st) == S_RD1;
  endproperty
  a_double: assert property (p_double)
    else $error("toggle compare without a first read");

  property p_fail_src;
    @(posedge clk_in) disable iff (reset_in)
    $rose(q.fail) |-> ($past(q.st) == S_RE && q.st == S_RST);
  endproperty
  a_fail_src: assert property (p_fail_src)
    else $error("failure not from a recheck");

  property p_rst_cmd;
    @(posedge clk_in) disable iff (reset_in)
    (q.st == S_RST && cyc.req) |-> ##1
      (!flash_we_n_out && flash_dq_out == CMD_RESET && flash_dq_oe_out);
  endproperty
  a_rst_cmd: assert property (p_rst_cmd)
    else $error("reset command not written as F0");

  property p_resume;
    @(posedge clk_in) disable iff (reset_in)
    ($past(q.st) == S_PAUSE && q.st != S_PAUSE) |-> q.st == S_RD1;
  endproperty
  a_resume: assert property (p_resume)
    else $error("check resumed past its double read");

  property p_wr_pulse;
    @(posedge clk_in) disable iff (reset_in)
    $fell(flash_we_n_out) |-> (!flash_we_n_out && flash_dq_oe_out)[*2]
      ##1 flash_we_n_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe width wrong");

endmodule

// >>> tb/fwsr_flash_model.sv
// behavioural byte-wide flash: command decode, status bits, array
// assumes pins driven from flops on clk_in; dq sampled at clk edges
`timescale 1ns/1ps
module fwsr_flash_model #(
  parameter int BUSY_CYC = 300,
  parameter int FAIL_CYC = 120,
  parameter int PROT_CYC = 80,
  parameter logic [1:0] PROT_SEC = 2'h3
) (
  input  wire logic        clk_in,
  input  wire logic [16:0] addr_in,
  input  wire logic        ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        dq_oe_in,
  output logic [7:0]       dq_out
);
  logic [7:0]  mem [0:131071];
  logic [7:0]  pd_q = 8'hFF, last_q = 8'h00, stat;
  logic [16:0] pa_q = '0;
  logic [2:0]  seq_q = '0;
  logic [1:0]  sec_q = '0;
  logic        we_q = 1'b1, oe_q = 1'b1, busy_q = 1'b0, erase_q = 1'b0;
  logic        chip_q = 1'b0, doom_q = 1'b0, fail_q = 1'b0;
  logic        t1_q = 1'b0, t2_q = 1'b0;
  // one sector is write-protected: busy for a short while, no change
  logic        prot_q = 1'b0;
  int          age_q = 0;
  int          n_resets = 0;

  initial
  begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
  end

  // ----------------------------------------------------------------
  // read path: no pull on dq, so a released bus shows junk
  // ----------------------------------------------------------------
  always_comb
  begin
    stat = {erase_q ? 1'b0 : ~pd_q[7], t1_q, fail_q, 2'b00, t2_q, 2'b00};
    if (ce_n_in || oe_n_in) dq_out = ~last_q;
    else if (busy_q) dq_out = stat;
    else dq_out = mem[addr_in];
  end

  // ----------------------------------------------------------------
  // write decode and algorithm progress
  // ----------------------------------------------------------------
  always @(posedge clk_in)
  begin
    we_q <= we_n_in;
    oe_q <= oe_n_in;
    if (!ce_n_in && !oe_n_in) last_q <= dq_out;
    if (!oe_n_in && oe_q && busy_q && !chip_q || !oe_n_in && oe_q && busy_q)
    begin
      t1_q <= ~t1_q;
      if (erase_q && (chip_q || addr_in[16:15] == sec_q))
        t2_q <= ~t2_q;
    end
    if (busy_q)
    begin
      age_q <= age_q + 1;
      if (doom_q)
      begin
        if (age_q == FAIL_CYC) fail_q <= 1'b1;
      end
      else if (age_q == (prot_q ? PROT_CYC : BUSY_CYC))
      begin
        busy_q <= 1'b0;
        if (!erase_q && !prot_q) mem[pa_q] <= pd_q;
        else if (erase_q)
          for (int i = 0; i < 131072; i++)
            if ((chip_q || (i >> 15) == int'(sec_q)) &&
                (i >> 15) != int'(PROT_SEC))
              mem[i] <= 8'hFF;
      end
    end
    if (we_n_in && !we_q && dq_oe_in)
    begin
      if (dq_in == 8'hF0)
      begin
        seq_q <= '0;
        busy_q <= 1'b0;
        fail_q <= 1'b0;
        doom_q <= 1'b0;
        n_resets <= n_resets + 1;
      end
      else if (!busy_q)
        case (seq_q)
          3'd0, 3'd4: seq_q <= (dq_in == 8'hAA) ? seq_q + 3'd1 : 3'd0;
          3'd1, 3'd5: seq_q <= (dq_in == 8'h55) ? seq_q + 3'd1 : 3'd0;
          3'd2: seq_q <= dq_in == 8'hA0 ? 3'd3 : dq_in == 8'h80 ? 3'd4 : 3'd0;
          3'd3:
          begin
            pa_q <= addr_in;
            pd_q <= dq_in;
            prot_q <= (addr_in[16:15] == PROT_SEC);
            doom_q <= |(dq_in & ~mem[addr_in]);
            erase_q <= 1'b0;
            busy_q <= 1'b1;
            age_q <= 0;
            seq_q <= '0;
          end
          default:
          begin
            seq_q <= '0;
            if (dq_in == 8'h30 || dq_in == 8'h10)
            begin
              erase_q <= 1'b1;
              prot_q <= (dq_in == 8'h30) &&
                        (addr_in[16:15] == PROT_SEC);
              chip_q <= (dq_in == 8'h10);
              sec_q <= addr_in[16:15];
              doom_q <= 1'b0;
              busy_q <= 1'b1;
              age_q <= 0;
            end
          end
        endcase
    end
  end
endmodule

// >>> tb/fwsr_host_bench.sv
// self-checking bench: register tasks drive operations on the model
// assumes the register map and status layout of fwsr_pkg
`timescale 1ns/1ps
module fwsr_host_bench;
  import fwsr_pkg::*;
  logic        clk_in = 1'b0, reset_in = 1'b1;
  logic [7:0]  reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out, st;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [16:0] flash_addr_out;
  logic        flash_ce_n_out, flash_we_n_out, flash_oe_n_out;
  logic        flash_dq_oe_out;
  logic [7:0]  flash_dq_out, flash_dq_in;
  int          err_count = 0, n_tests = 0;

  always #12.5 clk_in = ~clk_in;

  fwsr_host u_fwsr_host (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .flash_addr_out(flash_addr_out),
    .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out), .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out), .flash_dq_in(flash_dq_in));

  fwsr_flash_model #(.BUSY_CYC(300), .FAIL_CYC(120)) u_fwsr_flash_model (
    .clk_in(clk_in), .addr_in(flash_addr_out), .ce_n_in(flash_ce_n_out),
    .we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out),
    .dq_in(flash_dq_out), .dq_oe_in(flash_dq_oe_out),
    .dq_out(flash_dq_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // poll status until the given bit is set (bounded)
  task automatic wait_bit(input int b);
    for (int i = 0; i < 2000; i++)
    begin
      reg_rd(REG_STAT, st);
      if (st[b] === 1'b1) break;
    end
  endtask

  task automatic start_op(input logic [16:0] a, input logic [7:0] d,
                          input logic [7:0] ctrl);
    reg_wr(REG_ADDR, {15'h0, a});
    reg_wr(REG_WDATA, {24'h0, d});
    reg_wr(REG_CTRL, {24'h0, ctrl});
  endtask

  // start one operation, then poll status until done
  task automatic run_op(input logic [16:0] a, input logic [7:0] d,
                        input logic [7:0] ctrl);
    start_op(a, d, ctrl);
    wait_bit(1);
  endtask

  // strobes must never overlap on the pins
  always @(posedge clk_in)
    if (!reset_in && !flash_we_n_out && !flash_oe_n_out)
    begin
      err_count++;
      $display("mismatch at %0t: write and read strobes both low", $time);
    end

  initial
  begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    reg_rd(REG_STAT, st);
    check(st, 32'h0);
    reg_rd(8'h10, st);
    check(st, 32'h0);
    run_op(17'h00123, 8'h5A, 8'h01);
    check(st[15:0], 16'h5A02);
    check(u_fwsr_flash_model.mem[17'h00123], 8'h5A);
    run_op(17'h08004, 8'h00, 8'h11);
    check(st[15:0], 16'h0002);
    run_op(17'h08000, 8'h00, 8'h12);
    check(st[15:0], 16'hFF02);
    check(u_fwsr_flash_model.mem[17'h08004], 8'hFF);
    run_op(17'h00300, 8'h00, 8'h04);
    check(st[15:0], 16'hFF02);
    check(u_fwsr_flash_model.mem[17'h00123], 8'hFF);
    run_op(17'h00123, 8'h5A, 8'h01);
    check(st[15:0], 16'h5A02);
    // protected sector: short busy, then array data, nothing written
    run_op(17'h18010, 8'h00, 8'h01);
    check(st[15:0], 16'hFF02);
    check(u_fwsr_flash_model.mem[17'h18010], 8'hFF);
    run_op(17'h18000, 8'h00, 8'h12);
    check(st[15:0], 16'hFF02);
    // leave the check mid-way, then come back to a fresh double read
    start_op(17'h00124, 8'h33, 8'h01);
    repeat (40) @(posedge clk_in);
    reg_wr(REG_CTRL, 32'h00000020);
    wait_bit(3);
    check(st[3:0], 4'b1000);
    reg_wr(REG_CTRL, 32'h00000040);
    wait_bit(1);
    check(st[15:0], 16'h3302);
    run_op(17'h00123, 8'hA5, 8'h01);
    check(st[2:0], 3'b110);
    check(u_fwsr_flash_model.n_resets, 1);
    check(u_fwsr_flash_model.fail_q, 1'b0);
    run_op(17'h00123, 8'hFF, 8'h11);
    check(st[2:0], 3'b110);
    check(u_fwsr_flash_model.n_resets, 2);
    run_op(17'h00300, 8'h00, 8'h08);
    check(st[2:0], 3'b010);
    check(u_fwsr_flash_model.n_resets, 3);
    check(u_fwsr_flash_model.mem[17'h00123], 8'h5A);
    give_verdict();
  end
endmodule
